// ==== rtl/dad_alarm_detector.sv ====
// Drive alarm detector: link supervision, input checks and alarm code latch.
// Assumes link events arrive as one-cycle pulses from same-clock link logic;
// the node switch and emergency stop come from pins and are synchronised here.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Node address sampled once; outside 1..31 gives 82
// - Consecutive receive failures over limit give 83
// - Late or dropped alignment frame gives 84
// - Faulty alignment frame also gives 84
// - Watchdog exchange error each cycle gives 86
// - Emergency stop going open gives 87
// - Link-open with bad cycle setting gives 90
// - Alignment command in asynchronous mode gives 91
// - Gear ratio outside 1/100..100/1 gives 93
// - Unsupported motor and drive pairing gives 95
// - Self-diagnosis fault gives generic internal error
module dad_alarm_detector
  import dad_pkg::*;
#(
  parameter int TMO_W = 20 // Width of the alignment timeout counter
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [DAD_NODE_W-1:0] node_switch,
  input wire logic estop_closed,
  // Link events from same-clock link logic
  input wire logic link_active,
  input wire logic cycle_tick,
  input wire logic rx_ok,
  input wire logic rx_fail,
  input wire logic sync_frame,
  input wire logic sync_frame_bad,
  input wire logic wdog_err,
  input wire logic open_cmd,
  input wire logic open_cycle_bad,
  input wire logic sync_cmd,
  // Drive status inputs
  input wire logic motor_mismatch,
  input wire logic diag_fault,
  // Alarm outputs
  output logic [7:0] alarm_code,
  output logic alarm_active,
  output logic irq
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (TMO_W < 20 || TMO_W > 31) begin : g_chk
    $error("TMO_W must be 20 to 31");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic asyncm_r; // Asynchronous link mode
  logic [DAD_NEV-1:0] stat_r; // Sticky events
  logic [DAD_NEV-1:0] mask_r; // Interrupt mask
  logic [7:0] code_r; // Latched alarm code
  logic [7:0] errlim_r; // Consecutive error limit
  logic [TMO_W-1:0] tmo_r; // Alignment timeout
  logic [15:0] gear_num_r; // Gear numerator
  logic [15:0] gear_den_r; // Gear denominator
  logic [DAD_NODE_W-1:0] node_r; // Sampled node address
  logic node_done_r; // Node sample taken
  logic [7:0] errcnt_r; // Consecutive failure count
  logic [TMO_W-1:0] gap_r; // Cycles since last alignment frame
  logic [DAD_NODE_W-1:0] ns1_r, ns2_r, ns3_r; // Node switch synchroniser
  logic es1_r, es2_r, es3_r; // Emergency stop synchroniser
  logic estop_r; // Filtered emergency stop level
  logic [DAD_NEV-1:0] ev; // Events this cycle
  logic wr, rd;
  logic [DAD_NEV-1:0] w1c;

  // Single-cycle APB answer
  // Writes and clears act only while the clock enable is high
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite && ce;
  assign rd = psel && !pwrite;
  assign w1c = (wr && paddr == DAD_OFS_STAT) ? pwdata[DAD_NEV-1:0] : '0;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Three-stage capture; a change counts once stages two and three agree
  // Stop input resets to closed so no false open follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      ns1_r <= '0;
      ns2_r <= '0;
      ns3_r <= '0;
      es1_r <= 1'b1;
      es2_r <= 1'b1;
      es3_r <= 1'b1;
      estop_r <= 1'b1;
    end else if (ce) begin
      ns1_r <= node_switch;
      ns2_r <= ns1_r;
      ns3_r <= ns2_r;
      es1_r <= estop_closed;
      es2_r <= es1_r;
      es3_r <= es2_r;
      // Filtered level follows only an agreed value
      if (es2_r == es3_r) begin
        estop_r <= es3_r;
      end
    end
  end

  // ****************************************
  // Node address sample
  // ****************************************
  // Sampled once after reset, when the switch is through the synchroniser
  // Later switch moves are ignored until the next reset
  logic [1:0] nwait_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      nwait_r <= '0;
      node_done_r <= 1'b0;
      node_r <= '0;
    end else if (ce && !node_done_r) begin
      if (nwait_r == 2'h3 && ns2_r == ns3_r) begin
        node_r <= ns3_r;
        node_done_r <= 1'b1;
      end else if (nwait_r != 2'h3) begin
        nwait_r <= nwait_r + 2'h1;
      end
    end
  end

  // ****************************************
  // Consecutive receive failures
  // ****************************************
  // Run length of failed cycles; held at its ceiling so it cannot wrap
  always_ff @(posedge clk) begin
    if (rst) begin
      errcnt_r <= '0;
    end else if (ce) begin
      if (rx_ok) begin
        errcnt_r <= '0; // A good cycle breaks the run
      end else if (rx_fail && errcnt_r != 8'hFF) begin
        errcnt_r <= errcnt_r + 8'h01;
      end
    end
  end

  // ****************************************
  // Alignment frame timing
  // ****************************************
  // Counts cycles between frames while the link is active
  // Held at the timeout so a missing frame keeps its event raised
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_r <= '0;
    end else if (ce) begin
      if (!link_active || sync_frame) begin
        gap_r <= '0;
      end else if (gap_r != tmo_r) begin
        gap_r <= gap_r + 1'b1;
      end
    end
  end

  // ****************************************
  // Event detection
  // ****************************************
  // One bit per alarm source, high in every cycle its condition holds
  logic gear_bad;
  always_comb begin
    ev = '0;
    ev[DAD_EV_NODE] = node_done_r && (node_r < DAD_DIAG_NODE_MIN() ||
                      node_r > DAD_DIAG_NODE_MAX());
    ev[DAD_EV_COMM] = (errcnt_r > errlim_r);
    ev[DAD_EV_SYNC] = link_active && ((gap_r == tmo_r && !sync_frame) ||
                      (sync_frame && sync_frame_bad));
    ev[DAD_EV_WDOG] = cycle_tick && wdog_err;
    ev[DAD_EV_ESTOP] = !estop_r;
    ev[DAD_EV_CYCSET] = open_cmd && open_cycle_bad;
    ev[DAD_EV_SYNCCMD] = sync_cmd && asyncm_r;
    ev[DAD_EV_GEAR] = gear_bad;
    ev[DAD_EV_MOTOR] = motor_mismatch;
    ev[DAD_EV_DIAG] = diag_fault;
  end

  // Ratio below 1/100 or above 100/1; a zero term counts as out of range
  // Products fit in 24 bits for 16-bit terms
  logic [23:0] num_x, den_x;
  assign num_x = 24'(gear_num_r) * 24'(DAD_GEAR_RATIO);
  assign den_x = 24'(gear_den_r) * 24'(DAD_GEAR_RATIO);
  assign gear_bad = (gear_num_r == 16'h0000) || (gear_den_r == 16'h0000) ||
                    (num_x < 24'(gear_den_r)) || (den_x < 24'(gear_num_r));

  // Node range limits widened to the switch width
  function automatic logic [DAD_NODE_W-1:0] DAD_DIAG_NODE_MIN();
    return DAD_NODE_W'(DAD_NODE_MIN);
  endfunction : DAD_DIAG_NODE_MIN
  function automatic logic [DAD_NODE_W-1:0] DAD_DIAG_NODE_MAX();
    return DAD_NODE_W'(DAD_NODE_MAX);
  endfunction : DAD_DIAG_NODE_MAX

  // ****************************************
  // Sticky status and alarm code
  // ****************************************
  // Set wins over a one-written clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_r <= '0;
    end else if (ce) begin
      stat_r <= (stat_r & ~w1c) | ev;
    end
  end

  // Priority encoder from lowest code upward
  // Lower codes win when several sources fire in one cycle
  logic [7:0] first_code;
  always_comb begin
    first_code = DAD_CODE_NONE;
    if (ev[DAD_EV_NODE]) first_code = DAD_CODE_NODE;
    else if (ev[DAD_EV_COMM]) first_code = DAD_CODE_COMM;
    else if (ev[DAD_EV_SYNC]) first_code = DAD_CODE_SYNC;
    else if (ev[DAD_EV_WDOG]) first_code = DAD_CODE_WDOG;
    else if (ev[DAD_EV_ESTOP]) first_code = DAD_CODE_ESTOP;
    else if (ev[DAD_EV_CYCSET]) first_code = DAD_CODE_CYCSET;
    else if (ev[DAD_EV_SYNCCMD]) first_code = DAD_CODE_SYNCCMD;
    else if (ev[DAD_EV_GEAR]) first_code = DAD_CODE_GEAR;
    else if (ev[DAD_EV_MOTOR]) first_code = DAD_CODE_MOTOR;
    else if (ev[DAD_EV_DIAG]) first_code = DAD_CODE_DIAG;
  end

  // First alarm held; a clear only empties the latch when no event stands
  // A clear while the cause stands reloads the same code
  logic clr_req;
  assign clr_req = wr && paddr == DAD_OFS_CTRL && pwdata[DAD_CTRL_CLR_BIT];
  always_ff @(posedge clk) begin
    if (rst) begin
      code_r <= DAD_CODE_NONE;
    end else if (ce) begin
      if (code_r == DAD_CODE_NONE || clr_req) begin
        code_r <= first_code;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Software settings; writes land in the access phase only
  // A zero timeout would never let the gap counter move, so it becomes one
  always_ff @(posedge clk) begin
    if (rst) begin
      asyncm_r <= 1'b0;
      mask_r <= '0;
      errlim_r <= DAD_ERRLIM_RST;
      tmo_r <= TMO_W'(DAD_SYNCTMO_RST);
      gear_num_r <= 16'h0001;
      gear_den_r <= 16'h0001;
    end else if (wr) begin
      case (paddr)
        DAD_OFS_CTRL: asyncm_r <= pwdata[DAD_CTRL_ASYNC_BIT];
        DAD_OFS_MASK: mask_r <= pwdata[DAD_NEV-1:0];
        DAD_OFS_ERRLIM: errlim_r <= pwdata[7:0];
        DAD_OFS_SYNCTMO: tmo_r <= (pwdata[TMO_W-1:0] == '0) ? TMO_W'(1) : pwdata[TMO_W-1:0];
        DAD_OFS_GEAR: begin
          gear_num_r <= pwdata[31:16];
          gear_den_r <= pwdata[15:0];
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Combinational read mux; unmapped offsets read zero and flag an error
  logic [31:0] rdata;
  logic known;
  always_comb begin
    rdata = '0;
    known = 1'b1;
    case (paddr)
      DAD_OFS_CTRL: rdata[DAD_CTRL_ASYNC_BIT] = asyncm_r;
      DAD_OFS_STAT: rdata[DAD_NEV-1:0] = stat_r;
      DAD_OFS_MASK: rdata[DAD_NEV-1:0] = mask_r;
      DAD_OFS_CODE: rdata[7:0] = code_r;
      DAD_OFS_ERRLIM: rdata[7:0] = errlim_r;
      DAD_OFS_SYNCTMO: rdata[TMO_W-1:0] = tmo_r;
      DAD_OFS_GEAR: rdata = {gear_num_r, gear_den_r};
      DAD_OFS_NODE: rdata[DAD_NODE_W-1:0] = node_r;
      default: known = 1'b0;
    endcase
  end

  // Read data held in a flop, loaded in the setup cycle
  // Frozen with the rest of the state while the clock enable is low
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (ce && psel && !penable && rd) begin
      prdata <= rdata;
    end
  end

  // Error only in the access phase of an unmapped address
  assign pslverr = psel && penable && !known;

  // ****************************************
  // Outputs
  // ****************************************
  // Registered copy of the latch; trails the internal code by one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_code <= DAD_CODE_NONE;
      alarm_active <= 1'b0;
    end else if (ce) begin
      alarm_code <= code_r;
      alarm_active <= (code_r != DAD_CODE_NONE);
    end
  end

  // Level interrupt: any unmasked sticky bit
  assign irq = |(stat_r & mask_r);

endmodule : dad_alarm_detector

`default_nettype wire

// ==== rtl/dad_pkg.sv ====
// Package for the drive alarm detector: register map, alarm codes, timing.
// Assumes a 32-bit APB slave at 100 MHz on a single clock.
package dad_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] DAD_OFS_CTRL = 8'h00; // Control and clear
  localparam logic [7:0] DAD_OFS_STAT = 8'h04; // Sticky event status, write one to clear
  localparam logic [7:0] DAD_OFS_MASK = 8'h08; // Interrupt mask, one enables
  localparam logic [7:0] DAD_OFS_CODE = 8'h0C; // Latched alarm code
  localparam logic [7:0] DAD_OFS_ERRLIM = 8'h10; // Consecutive error limit
  localparam logic [7:0] DAD_OFS_SYNCTMO = 8'h14; // Alignment frame timeout in cycles
  localparam logic [7:0] DAD_OFS_GEAR = 8'h18; // Gear numerator and denominator
  localparam logic [7:0] DAD_OFS_NODE = 8'h1C; // Sampled node address

  // ****************************************
  // Control fields
  // ****************************************
  localparam int DAD_CTRL_CLR_BIT = 0; // Write one clears the latched code
  localparam int DAD_CTRL_ASYNC_BIT = 1; // Link runs in asynchronous mode

  // ****************************************
  // Event status bit positions
  // ****************************************
  localparam int DAD_EV_NODE = 0;
  localparam int DAD_EV_COMM = 1;
  localparam int DAD_EV_SYNC = 2;
  localparam int DAD_EV_WDOG = 3;
  localparam int DAD_EV_ESTOP = 4;
  localparam int DAD_EV_CYCSET = 5;
  localparam int DAD_EV_SYNCCMD = 6;
  localparam int DAD_EV_GEAR = 7;
  localparam int DAD_EV_MOTOR = 8;
  localparam int DAD_EV_DIAG = 9;
  localparam int DAD_NEV = 10;

  // ****************************************
  // Alarm codes
  // ****************************************
  localparam logic [7:0] DAD_CODE_NONE = 8'h00;
  localparam logic [7:0] DAD_CODE_NODE = 8'd82;
  localparam logic [7:0] DAD_CODE_COMM = 8'd83;
  localparam logic [7:0] DAD_CODE_SYNC = 8'd84;
  localparam logic [7:0] DAD_CODE_WDOG = 8'd86;
  localparam logic [7:0] DAD_CODE_ESTOP = 8'd87;
  localparam logic [7:0] DAD_CODE_CYCSET = 8'd90;
  localparam logic [7:0] DAD_CODE_SYNCCMD = 8'd91;
  localparam logic [7:0] DAD_CODE_GEAR = 8'd93;
  localparam logic [7:0] DAD_CODE_MOTOR = 8'd95;
  localparam logic [7:0] DAD_CODE_DIAG = 8'hFF; // Generic internal error, arbitrary

  // ****************************************
  // Limits and reset values
  // ****************************************
  localparam logic [4:0] DAD_NODE_MIN = 5'd1;
  localparam logic [4:0] DAD_NODE_MAX = 5'd31;
  localparam int DAD_NODE_W = 6; // Switch width; values above 31 possible
  localparam int DAD_GEAR_RATIO = 100; // Max ratio either way
  localparam logic [7:0] DAD_ERRLIM_RST = 8'd2;
  localparam int DAD_CLK_MHZ = 100;
  localparam int DAD_SYNCTMO_US = 1000; // Default alignment frame timeout
  localparam logic [19:0] DAD_SYNCTMO_RST = 20'(DAD_SYNCTMO_US * DAD_CLK_MHZ);

endpackage : dad_pkg

// ==== bench/dad_alarm_props.sv ====
// Port checker for the drive alarm detector.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module dad_alarm_props
  import dad_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Alarm outputs
  input wire logic [7:0] alarm_code,
  input wire logic alarm_active,
  input wire logic irq
);
  // ****************
  // Helpers
  // ****************
  logic acc; // Access phase
  logic clr_wr; // Code clear write
  logic st_wr; // Status or mask write
  assign acc = psel && penable;
  assign clr_wr = acc && pwrite && paddr == DAD_OFS_CTRL && pwdata[DAD_CTRL_CLR_BIT];
  assign st_wr = acc && pwrite && (paddr == DAD_OFS_STAT || paddr == DAD_OFS_MASK);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Code shown with no clear in the cycle before
  sequence s_held;
    !clr_wr ##1 alarm_code != DAD_CODE_NONE;
  endsequence
  AST_READY: assert property (acc |-> pready)
    else $error("pready low in access phase");
  AST_SLVERR_BAD: assert property (acc && paddr > DAD_OFS_NODE |-> pslverr)
    else $error("unmapped access without error");
  AST_SLVERR_OK: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  AST_PRDATA_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  AST_ACTIVE: assert property (alarm_active == (alarm_code != DAD_CODE_NONE))
    else $error("alarm flag disagrees with code");
  AST_LATCH: assert property (s_held |=> $stable(alarm_code))
    else $error("latched code changed without clear");
  AST_IRQ_STICKY: assert property (irq && !st_wr |=> irq)
    else $error("interrupt dropped without status write");
  AST_CODE_LEGAL: assert property (alarm_code inside {8'h00, 8'h52, 8'h53, 8'h54, 8'h56,
    8'h57, 8'h5A, 8'h5B, 8'h5D, 8'h5F, 8'hFF})
    else $error("alarm code outside the defined set");
endmodule : dad_alarm_props
bind dad_alarm_detector dad_alarm_props i_dad_alarm_props (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .alarm_code, .alarm_active, .irq
);
`default_nettype wire

// ==== bench/dad_link_master.sv ====
// Fieldbus master model: cyclic link events for the alarm detector.
// Assumes the detector shares its clock; faults only on bench command.
`timescale 1ns/100ps
`default_nettype none
module dad_link_master #(
  parameter int PERIOD = 10 // Link cycle in clocks
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench controls: link open and fault injection
  input wire logic en,
  input wire logic fail,
  input wire logic drop,
  input wire logic bad,
  input wire logic wd_bad,
  // Link events
  output logic link_active,
  output logic cycle_tick,
  output logic rx_ok,
  output logic rx_fail,
  output logic sync_frame,
  output logic sync_frame_bad,
  output logic wdog_err
);
  logic [7:0] cnt_r; // Cycle phase
  // Free-running cycle counter, fixed period with no jitter
  always_ff @(posedge clk) begin
    cnt_r <= (rst || cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
  end
  assign cycle_tick = cnt_r == 8'(PERIOD - 1);
  assign link_active = en;
  assign rx_ok = cycle_tick && en && !fail;
  assign rx_fail = cycle_tick && en && fail;
  // Frame every cycle unless dropping
  assign sync_frame = cycle_tick && en && !drop;
  assign sync_frame_bad = sync_frame && bad;
  // Watchdog field updated each cycle unless told otherwise
  assign wdog_err = cycle_tick && en && wd_bad;
endmodule : dad_link_master
`default_nettype wire

// ==== bench/drive_alarm_detector_tb.sv ====
// Testbench for the drive alarm detector: one APB test per alarm source.
// Assumes dad_link_master as link partner; ce runs high except in one freeze test.
`timescale 1ns/100ps
`default_nettype none
module drive_alarm_detector_tb
  import dad_pkg::*;
;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, alarm_active, irq;
  logic [7:0] paddr, alarm_code;
  logic [31:0] pwdata, prdata;
  logic [DAD_NODE_W-1:0] node_switch;
  logic estop_closed, motor_mismatch, diag_fault, open_cmd, open_cycle_bad, sync_cmd;
  logic link_active, cycle_tick, rx_ok, rx_fail, sync_frame, sync_frame_bad, wdog_err;
  logic en, fail, drop, bad, wd_bad;
  int err_count, n_tests;
  logic [31:0] gv [4] = '{32'h00640001, 32'h00650001, 32'h00010064, 32'h00010065};
  logic gx [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  dad_alarm_detector i_dad_alarm_detector (.clk, .rst, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .node_switch, .estop_closed,
    .link_active, .cycle_tick, .rx_ok, .rx_fail, .sync_frame, .sync_frame_bad, .wdog_err,
    .open_cmd, .open_cycle_bad, .sync_cmd, .motor_mismatch, .diag_fault, .alarm_code,
    .alarm_active, .irq);
  dad_link_master i_dad_link_master (.clk, .rst, .en, .fail, .drop, .bad, .wd_bad,
    .link_active, .cycle_tick, .rx_ok, .rx_fail, .sync_frame, .sync_frame_bad, .wdog_err);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Verdict and end of run
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One APB transfer, bounded wait on pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      conclude();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(s, e, q);
  endtask : rdc
  // Wait for the alarm flag, then read the latched code
  task automatic hit(input logic [7:0] c);
    int n;
    n = 0;
    while (alarm_active !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("alarm raised", 32'h1, {31'h0, alarm_active});
    if (n >= 400) begin
      conclude();
    end
    rdc(DAD_OFS_CODE, {24'h0, c}, "alarm code");
  endtask : hit
  // Clear status and code, expect an empty latch
  task automatic clr(input string s);
    // Let a pending frame or good cycle remove the cause first
    repeat (12) @(posedge clk);
    wr(DAD_OFS_STAT, 32'h3FF);
    wr(DAD_OFS_CTRL, 32'h1);
    rdc(DAD_OFS_CODE, 32'h0, "code cleared");
    $display("test %s done", s);
  endtask : clr
  task automatic pulse_open(input logic b);
    open_cmd <= 1'b1;
    open_cycle_bad <= b;
    @(posedge clk);
    open_cmd <= 1'b0;
    open_cycle_bad <= 1'b0;
  endtask : pulse_open
  // Mid-run power-on with a new switch setting, then time for the sample
  task automatic por(input logic [DAD_NODE_W-1:0] s);
    node_switch <= s;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : por
  // ****************
  // Main sequence
  // ****************
  initial begin
    {rst, ce, psel, penable, pwrite, paddr, pwdata} = {2'b11, 3'h0, 8'h00, 32'h0};
    {node_switch, estop_closed, motor_mismatch, diag_fault} = {6'h00, 3'h4};
    {open_cmd, open_cycle_bad, sync_cmd, en, fail, drop, bad, wd_bad} = 8'h00;
    {err_count, n_tests} = {32'h0, 32'h0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    hit(DAD_CODE_NODE);
    por(6'h28);
    hit(DAD_CODE_NODE);
    rdc(DAD_OFS_NODE, 32'h28, "node above range");
    por(6'h05);
    node_switch <= 6'h00;
    repeat (10) @(posedge clk);
    chk("node in range", 32'h0, {31'h0, alarm_active});
    rdc(DAD_OFS_NODE, 32'h05, "node sampled once");
    clr("node");
    rdc(DAD_OFS_ERRLIM, 32'h2, "errlim reset");
    rdc(DAD_OFS_GEAR, 32'h00010001, "gear reset");
    rdc(8'h40, 32'h0, "unmapped read");
    wr(DAD_OFS_CODE, 32'hFF);
    rdc(DAD_OFS_CODE, 32'h0, "code read only");
    $display("test regs done");
    // Two failures pass at limit two, three trip
    wr(DAD_OFS_SYNCTMO, 32'h14);
    {en, fail} <= 2'b11;
    repeat (20) @(posedge clk);
    fail <= 1'b0;
    repeat (30) @(posedge clk);
    chk("two failures", 32'h0, {31'h0, alarm_active});
    fail <= 1'b1;
    repeat (30) @(posedge clk);
    fail <= 1'b0;
    hit(DAD_CODE_COMM);
    clr("comm");
    chk("steady frames", 32'h0, {31'h0, alarm_active});
    drop <= 1'b1;
    hit(DAD_CODE_SYNC);
    drop <= 1'b0;
    clr("sync drop");
    bad <= 1'b1;
    repeat (10) @(posedge clk);
    bad <= 1'b0;
    hit(DAD_CODE_SYNC);
    clr("sync bad");
    wd_bad <= 1'b1;
    repeat (10) @(posedge clk);
    {wd_bad, diag_fault} <= 2'b01;
    hit(DAD_CODE_WDOG);
    rdc(DAD_OFS_CODE, {24'h0, DAD_CODE_WDOG}, "first code kept");
    {en, diag_fault} <= 2'b00;
    clr("wdog");
    ce <= 1'b0;
    diag_fault <= 1'b1;
    repeat (20) @(posedge clk);
    chk("frozen by ce", 32'h0, {31'h0, alarm_active});
    ce <= 1'b1;
    hit(DAD_CODE_DIAG);
    diag_fault <= 1'b0;
    clr("diag");
    estop_closed <= 1'b0;
    hit(DAD_CODE_ESTOP);
    estop_closed <= 1'b1;
    repeat (100) @(posedge clk);
    clr("estop");
    // Mismatch with interrupt masked, unmasked, then cleared
    motor_mismatch <= 1'b1;
    hit(DAD_CODE_MOTOR);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(DAD_OFS_MASK, 32'h1 << DAD_EV_MOTOR);
    motor_mismatch <= 1'b0;
    rdc(DAD_OFS_STAT, 32'h1 << DAD_EV_MOTOR, "status sticky");
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(DAD_OFS_STAT, 32'h1 << DAD_EV_MOTOR);
    @(negedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(DAD_OFS_MASK, 32'h0);
    clr("motor");
    pulse_open(1'b1);
    hit(DAD_CODE_CYCSET);
    clr("cycle set");
    pulse_open(1'b0);
    repeat (5) @(posedge clk);
    chk("good reopen", 32'h0, {31'h0, alarm_active});
    for (int i = 0; i < 2; i++) begin
      wr(DAD_OFS_CTRL, {30'h0, i[0], 1'b0});
      sync_cmd <= 1'b1;
      @(posedge clk);
      sync_cmd <= 1'b0;
      repeat (5) @(posedge clk);
      chk("align cmd", i[0] ? {24'h0, DAD_CODE_SYNCCMD} : 32'h0, {24'h0, alarm_code});
    end
    clr("sync cmd");
    for (int i = 0; i < 4; i++) begin
      wr(DAD_OFS_GEAR, gv[i]);
      repeat (5) @(posedge clk);
      chk("gear code", gx[i] ? {24'h0, DAD_CODE_GEAR} : 32'h0, {24'h0, alarm_code});
      wr(DAD_OFS_GEAR, 32'h00010001);
      clr("gear");
    end
    conclude();
  end
endmodule : drive_alarm_detector_tb
`default_nettype wire
